// File: include/rdto_pkg.sv
// Constants and helpers for the resonant-mode edge offset block
package rdto_pkg;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_BRIDGE_D_FALL = 8'h4F;
  localparam logic [ADDR_W-1:0] OFS_RECT1_RISE = 8'h51;
  localparam logic [ADDR_W-1:0] OFS_RECT1_FALL = 8'h53;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h58;
  localparam logic [DATA_W-1:0] RST_OFFSET = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;

  // Status register fields
  localparam int STAT_BRIDGE_BIT = 0;
  localparam int STAT_RECT1_BIT = 1;
  localparam int STAT_MODE_BIT = 2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int STEP_NS = 5;
  localparam int MAX_OFFSET_NS = 1275;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CNT_W = 16;
  localparam int LEAD_W = 6;

  // Offset code to whole clock cycles, rounded up so no gap shrinks
  function automatic logic [LEAD_W-1:0] rdto_code_to_cyc(
    input logic [DATA_W-1:0] code);
    logic [11:0] span_ns;
    span_ns = 12'(code) * 12'(STEP_NS) + 12'(CLK_PERIOD_NS - 1);
    return LEAD_W'(span_ns / 12'(CLK_PERIOD_NS));
  endfunction

endpackage

// File: core/rdto_core.sv
// Resonant-mode edge offsets for the bridge drive and first rectifier
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// (RULE1) Bridge D falls offset before cycle end
// (RULE2) Rectifier rises offset after sense rise
// (RULE3) Rectifier falls offset before sense fall
// (RULE4) Codes unsigned 8-bit, 5 ns per step
// (RULE5) Offsets apply only in resonant mode
module rdto_core
  import rdto_pkg::*;
#(
  parameter int CYC_W = CNT_W
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // Timing engine
  input wire logic i_resonant_mode,
  input wire logic i_cycle_start,
  input wire logic [CYC_W-1:0] i_cycle_len,
  input wire logic i_bridge_d_raw,
  input wire logic i_ac_sense_input,
  // Drive outputs
  output logic o_bridge_drive_d,
  output logic o_sync_rect_first
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [DATA_W-1:0] bridge_d_fall_offset_ff;
  logic [DATA_W-1:0] rect1_rise_offset_ff;
  logic [DATA_W-1:0] rect1_fall_offset_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_bridge_d_fall_offset;
  logic [DATA_W-1:0] nxt_rect1_rise_offset;
  logic [DATA_W-1:0] nxt_rect1_fall_offset;
  logic [DATA_W-1:0] nxt_rdata;

  always_comb begin
    nxt_bridge_d_fall_offset = bridge_d_fall_offset_ff;
    nxt_rect1_rise_offset = rect1_rise_offset_ff;
    nxt_rect1_fall_offset = rect1_fall_offset_ff;
    nxt_rdata = RDATA_IDLE;
    if (i_wr) begin
      unique case (i_addr)
        OFS_BRIDGE_D_FALL: nxt_bridge_d_fall_offset = i_wdata;
        OFS_RECT1_RISE: nxt_rect1_rise_offset = i_wdata;
        OFS_RECT1_FALL: nxt_rect1_fall_offset = i_wdata;
        default: nxt_rdata = RDATA_IDLE;
      endcase
    end
    if (i_rd) begin
      unique case (i_addr)
        OFS_BRIDGE_D_FALL: nxt_rdata = bridge_d_fall_offset_ff;
        OFS_RECT1_RISE: nxt_rdata = rect1_rise_offset_ff;
        OFS_RECT1_FALL: nxt_rdata = rect1_fall_offset_ff;
        OFS_STATUS: begin
          nxt_rdata[STAT_BRIDGE_BIT] = o_bridge_drive_d;
          nxt_rdata[STAT_RECT1_BIT] = o_sync_rect_first;
          nxt_rdata[STAT_MODE_BIT] = i_resonant_mode;
        end
        // Unmapped reads return zero
        default: nxt_rdata = RDATA_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bridge_d_fall_offset_ff <= RST_OFFSET;
      rect1_rise_offset_ff <= RST_OFFSET;
      rect1_fall_offset_ff <= RST_OFFSET;
      rdata_ff <= RDATA_IDLE;
    end else begin
      bridge_d_fall_offset_ff <= nxt_bridge_d_fall_offset;
      rect1_rise_offset_ff <= nxt_rect1_rise_offset;
      rect1_fall_offset_ff <= nxt_rect1_fall_offset;
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_rdata = rdata_ff;

  rdata_idle_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !i_rd |=> o_rdata == RDATA_IDLE)
    else $error("read data not idle outside a read");

  bridge_write_a: assert property ( // RULE1
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_wr && i_addr == OFS_BRIDGE_D_FALL)
      |=> bridge_d_fall_offset_ff == $past(i_wdata))
    else $error("bridge offset write did not land");

  rise_write_a: assert property ( // RULE2
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_wr && i_addr == OFS_RECT1_RISE)
      |=> rect1_rise_offset_ff == $past(i_wdata))
    else $error("rectifier rise offset write did not land");

  fall_write_a: assert property ( // RULE3
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_wr && i_addr == OFS_RECT1_FALL)
      |=> rect1_fall_offset_ff == $past(i_wdata))
    else $error("rectifier fall offset write did not land");

  // ****************************************************************
  // Offset codes in clock cycles
  // ****************************************************************
  // 5 ns steps are finer than the 40 ns clock; rounding up keeps
  // every dead time at least as long as programmed.
  logic [LEAD_W-1:0] bridge_lead_cyc;
  logic [LEAD_W-1:0] rise_delay_cyc;
  logic [LEAD_W-1:0] fall_lead_cyc;

  assign bridge_lead_cyc = rdto_code_to_cyc(bridge_d_fall_offset_ff); // RULE4
  assign rise_delay_cyc = rdto_code_to_cyc(rect1_rise_offset_ff); // RULE4
  assign fall_lead_cyc = rdto_code_to_cyc(rect1_fall_offset_ff); // RULE4

  bridge_scale_a: assert property ( // RULE4
    @(posedge i_clk) disable iff (!i_reset_n)
    (12'(bridge_lead_cyc) * 12'(CLK_PERIOD_NS)
      >= 12'(bridge_d_fall_offset_ff) * 12'(STEP_NS))
    && (12'(bridge_lead_cyc) * 12'(CLK_PERIOD_NS)
      < 12'(bridge_d_fall_offset_ff) * 12'(STEP_NS) + 12'(CLK_PERIOD_NS)))
    else $error("bridge offset code not scaled at 5 ns per step");

  fall_scale_a: assert property ( // RULE4
    @(posedge i_clk) disable iff (!i_reset_n)
    (12'(fall_lead_cyc) * 12'(CLK_PERIOD_NS)
      >= 12'(rect1_fall_offset_ff) * 12'(STEP_NS))
    && (12'(fall_lead_cyc) * 12'(CLK_PERIOD_NS)
      < 12'(rect1_fall_offset_ff) * 12'(STEP_NS) + 12'(CLK_PERIOD_NS)))
    else $error("fall offset code not scaled at 5 ns per step");

  full_scale_a: assert property ( // RULE4
    @(posedge i_clk) disable iff (!i_reset_n)
    (rect1_fall_offset_ff == 8'hFF) |-> (fall_lead_cyc
      == LEAD_W'((MAX_OFFSET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS)))
    else $error("full scale code not a 1275 ns lead");

  // ****************************************************************
  // Bridge drive D
  // ****************************************************************
  logic [CYC_W-1:0] cyc_cnt_ff;
  logic bridge_ff;
  logic [CYC_W-1:0] nxt_cyc_cnt;
  logic nxt_bridge;
  logic [CYC_W-1:0] cyc_pos;
  logic bridge_fits;

  always_comb begin
    // Saturate so a missing cycle start cannot wrap the position
    if (i_cycle_start) begin
      cyc_pos = '0;
    end else if (&cyc_cnt_ff) begin
      cyc_pos = cyc_cnt_ff;
    end else begin
      cyc_pos = cyc_cnt_ff + CYC_W'(1);
    end
    nxt_cyc_cnt = cyc_pos;
    // Pulse must be over before the last lead cycles of the period
    bridge_fits = ({1'b0, cyc_pos} + (CYC_W + 1)'(bridge_lead_cyc))
      < {1'b0, i_cycle_len}; // RULE1
    nxt_bridge = i_resonant_mode ? (i_bridge_d_raw && bridge_fits)
      : i_bridge_d_raw; // RULE5
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cyc_cnt_ff <= '0;
      bridge_ff <= 1'b0;
    end else begin
      cyc_cnt_ff <= nxt_cyc_cnt;
      bridge_ff <= nxt_bridge;
    end
  end

  assign o_bridge_drive_d = bridge_ff;

  bridge_pass_a: assert property ( // RULE1
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_resonant_mode && bridge_fits)
      |=> o_bridge_drive_d == $past(i_bridge_d_raw))
    else $error("bridge drive cut outside the falling lead");

  cycle_restart_a: assert property ( // RULE1
    @(posedge i_clk) disable iff (!i_reset_n)
    i_cycle_start |=> cyc_cnt_ff == '0)
    else $error("cycle position not cleared at cycle start");

  // ****************************************************************
  // First synchronous rectifier
  // ****************************************************************
  // The sense fall cannot be seen ahead, so it is predicted from the
  // previous high time; the first half-wave after reset stays off.
  logic ac_q_ff;
  logic [CYC_W-1:0] hi_cnt_ff;
  logic [CYC_W-1:0] hi_len_ff;
  logic rect_ff;
  logic nxt_ac_q;
  logic [CYC_W-1:0] nxt_hi_cnt;
  logic [CYC_W-1:0] nxt_hi_len;
  logic nxt_rect;
  logic ac_rise;
  logic ac_fall;
  logic rect_after_rise;
  logic rect_before_fall;

  always_comb begin
    ac_rise = i_ac_sense_input && !ac_q_ff;
    ac_fall = !i_ac_sense_input && ac_q_ff;
    nxt_ac_q = i_ac_sense_input;
    // Saturate so a very long half-wave is not read as no history
    nxt_hi_len = !ac_fall ? hi_len_ff
      : (&hi_cnt_ff) ? hi_cnt_ff : hi_cnt_ff + CYC_W'(1);
    if (ac_rise) begin
      nxt_hi_cnt = '0;
    end else if (i_ac_sense_input && !(&hi_cnt_ff)) begin
      nxt_hi_cnt = hi_cnt_ff + CYC_W'(1);
    end else begin
      nxt_hi_cnt = hi_cnt_ff;
    end
    rect_after_rise = nxt_hi_cnt >= CYC_W'(rise_delay_cyc); // RULE2
    rect_before_fall = ({1'b0, nxt_hi_cnt}
      + (CYC_W + 1)'(fall_lead_cyc)) < {1'b0, hi_len_ff}; // RULE3
    nxt_rect = i_resonant_mode
      ? (i_ac_sense_input && rect_after_rise && rect_before_fall)
      : i_ac_sense_input; // RULE5
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ac_q_ff <= 1'b0;
      hi_cnt_ff <= '0;
      hi_len_ff <= '0;
      rect_ff <= 1'b0;
    end else begin
      ac_q_ff <= nxt_ac_q;
      hi_cnt_ff <= nxt_hi_cnt;
      hi_len_ff <= nxt_hi_len;
      rect_ff <= nxt_rect;
    end
  end

  assign o_sync_rect_first = rect_ff;

  rect_sense_low_a: assert property ( // RULE2
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_resonant_mode && !i_ac_sense_input) |=> !o_sync_rect_first)
    else $error("rectifier high while the sense input is low");

  rect_no_history_a: assert property ( // RULE3
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_resonant_mode && hi_len_ff == '0) |=> !o_sync_rect_first)
    else $error("rectifier high with no stored high time");

  rect_window_on_a: assert property ( // RULE3
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_resonant_mode && i_ac_sense_input && rect_after_rise
      && rect_before_fall) |=> o_sync_rect_first)
    else $error("rectifier low inside its conduction window");

  // ****************************************************************
  // Checks
  // ****************************************************************
  bridge_lead_a: assert property ( // RULE1
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_resonant_mode && !bridge_fits) |=> !o_bridge_drive_d)
    else $error("bridge drive high inside the falling lead");

  rect_rise_hold_a: assert property ( // RULE2
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_resonant_mode && ac_rise && rise_delay_cyc > 6'h00)
      |=> !o_sync_rect_first)
    else $error("rectifier rose before its delay");

  rect_rise_on_a: assert property ( // RULE2
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_resonant_mode && i_ac_sense_input
      && nxt_hi_cnt == CYC_W'(rise_delay_cyc) && rect_before_fall)
      |=> o_sync_rect_first)
    else $error("rectifier did not rise after its delay");

  rect_fall_lead_a: assert property ( // RULE3
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_resonant_mode && !rect_before_fall) |=> !o_sync_rect_first)
    else $error("rectifier high inside the falling lead");

  step_scale_a: assert property ( // RULE4
    @(posedge i_clk) disable iff (!i_reset_n)
    (12'(rise_delay_cyc) * 12'(CLK_PERIOD_NS)
      >= 12'(rect1_rise_offset_ff) * 12'(STEP_NS))
    && (12'(rise_delay_cyc) * 12'(CLK_PERIOD_NS)
      < 12'(rect1_rise_offset_ff) * 12'(STEP_NS) + 12'(CLK_PERIOD_NS)))
    else $error("offset code not scaled at 5 ns per step");

  mode_bypass_a: assert property ( // RULE5
    @(posedge i_clk) disable iff (!i_reset_n)
    !i_resonant_mode |=> (o_sync_rect_first == $past(i_ac_sense_input))
      && (o_bridge_drive_d == $past(i_bridge_d_raw)))
    else $error("outputs altered outside resonant mode");

endmodule
`default_nettype wire

// File: test/rdto_stage_model.sv
// Power stage model: switching cycle, raw bridge drive, ac sense
`timescale 1ns/1ps
`default_nettype none
module rdto_stage_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Waveform shape
  input wire logic [15:0] i_len,
  input wire logic [7:0] i_ac_hi,
  input wire logic [7:0] i_ac_lo,
  // Engine and sense
  output logic o_cycle_start,
  output logic o_bridge_d_raw,
  output logic o_ac_sense_input
);
  logic [15:0] pos_ff;
  logic [15:0] nxt_pos;
  logic [7:0] ac_ff;
  always_comb begin
    nxt_pos = (pos_ff + 16'h1 >= i_len) ? 16'h0 : pos_ff + 16'h1;
  end
  // Raw low on the start clock so the end edge comes from the lead
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pos_ff <= 16'h0;
      ac_ff <= 8'h0;
      o_cycle_start <= 1'b0;
      o_bridge_d_raw <= 1'b0;
      o_ac_sense_input <= 1'b0;
    end else begin
      pos_ff <= nxt_pos;
      o_cycle_start <= nxt_pos == 16'h0;
      o_bridge_d_raw <= nxt_pos != 16'h0;
      ac_ff <= ac_ff + 8'h1;
      if (ac_ff + 8'h1 >= (o_ac_sense_input ? i_ac_hi : i_ac_lo)) begin
        ac_ff <= 8'h0;
        o_ac_sense_input <= !o_ac_sense_input;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/resonant_dead_time_offsets_test.sv
// Self-checking bench for the resonant edge offset block
`timescale 1ns/1ps
`default_nettype none
module resonant_dead_time_offsets_test import rdto_pkg::*;;
  logic i_clk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0, mode = 0;
  logic cs, raw, ac, o_b, o_r, eb = 0, er = 0, en = 0, ap = 0;
  logic [7:0] i_addr = 0, i_wdata = 0, rdata, hi = 20, lo = 10;
  logic [7:0] sc[3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] ad[3] = '{OFS_BRIDGE_D_FALL, OFS_RECT1_RISE, OFS_RECT1_FALL};
  logic [15:0] len = 40, p = 0, h = 0, hl = 0;
  logic [31:0] seed = 32'h0b3d;
  int bad_count = 0, n_tests = 0;
  always #20 i_clk = ~i_clk;
  rdto_core u_rdto_core (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(rdata), .i_resonant_mode(mode), .i_cycle_start(cs),
    .i_cycle_len(len), .i_bridge_d_raw(raw), .i_ac_sense_input(ac),
    .o_bridge_drive_d(o_b), .o_sync_rect_first(o_r));
  rdto_stage_model u_rdto_stage_model (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_len(len), .i_ac_hi(hi), .i_ac_lo(lo),
    .o_cycle_start(cs), .o_bridge_d_raw(raw), .o_ac_sense_input(ac));
  function automatic int cyc(input logic [7:0] c);
    return (int'(c) * STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task chk(input string s, input logic [7:0] e, input logic [7:0] v);
    n_tests++;
    if (v !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, v);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk("rdata", e, rdata);
  endtask
  task rd_stat;
    logic [7:0] e;
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= OFS_STATUS;
    @(posedge i_clk);
    e = RDATA_IDLE;
    e[STAT_BRIDGE_BIT] = eb;
    e[STAT_RECT1_BIT] = er;
    e[STAT_MODE_BIT] = mode;
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk("status", e, rdata);
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ****************************************************************
  // Reference model: position in cycle, high time of the sense input
  // ****************************************************************
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      p = 16'h0;
      h = 16'h0;
      hl = 16'h0;
      ap = 1'b0;
      eb <= 1'b0;
      er <= 1'b0;
    end else begin
      p = cs ? 16'h0 : (&p ? p : p + 16'h1);
      h = (ac && !ap) ? 16'h0 : (ac ? h + 16'h1 : h);
      eb <= mode ? raw && (int'(p) + cyc(sc[0]) < int'(len)) : raw;
      er <= mode ? ac && int'(h) >= cyc(sc[1]) &&
        int'(h) + cyc(sc[2]) < int'(hl) : ac;
      if (!ac && ap)
        hl = h + 16'h1;
      ap = ac;
    end
  end
  always @(negedge i_clk) begin
    if (en) begin
      chk("bridge_drive_d", 8'(eb), 8'(o_b));
      chk("sync_rect_first", 8'(er), 8'(o_r));
    end
  end
  initial begin
    #1000000;
    bad_count++;
    results;
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    en <= 1'b1;
    for (int k = 0; k < 3; k++) rd(ad[k], RST_OFFSET);
    wr(8'h50, 8'hAA);
    rd(8'h50, RDATA_IDLE);
    // Zero, full scale, then the 8/9 rounding step, then random codes
    for (int r = 0; r < 7; r++) begin
      for (int k = 0; k < 3; k++) begin
        sc[k] = r == 0 ? 8'h00 : r == 1 ? 8'hFF :
          r == 2 ? 8'(8 + k) : 8'(rnd());
        wr(ad[k], sc[k]);
        rd(ad[k], sc[k]);
      end
      len <= 16'(20 + rnd() % 40);
      hi <= 8'(8 + rnd() % 40);
      lo <= 8'(4 + rnd() % 20);
      mode <= 1'b1;
      repeat (200) @(posedge i_clk);
      rd_stat();
      repeat (200) @(posedge i_clk);
      mode <= 1'b0;
      repeat (10) @(posedge i_clk);
      rd_stat();
    end
    results;
  end
endmodule
`default_nettype wire
